// >>> design/mul_div_logic_op_decoder.sv
`timescale 1ns/100ps
`default_nettype none
`include "opd_regs.svh"
module mul_div_logic_op_decoder #(
    parameter bit NARROW_BUS = 1'b0
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic in_valid,
    input wire logic [7:0] in_byte,
    input wire logic [7:0] count_register_low,
    output logic in_ready,
    output opd_pkg::op_class_t op_class,
    output opd_pkg::shift_op_t shift_op_select_field,
    output logic op_word,
    output logic op_mem,
    output logic [8:0] cyc_min,
    output logic [8:0] cyc_max,
    output logic decode_valid,
    output logic busy,
    output logic done,
    output logic invalid
);

    // ----------------------------------------
    // Class decode
    // ----------------------------------------
    // Shared by the opcode and second-byte stages; groups need the reg field
    function automatic opd_pkg::op_class_t classify(input logic [7:0] opc, input logic [2:0] r);
        classify = opd_pkg::op_invalid;
        if ((opc & `MASK_W) == `OPC_GRP3) begin
            if (r == `REG_SMUL) classify = opd_pkg::op_smul;
            else if (r == `REG_UDIV) classify = opd_pkg::op_udiv;
            else if (r == `REG_SDIV) classify = opd_pkg::op_sdiv;
            else if (r == `REG_TEST) classify = opd_pkg::op_test_imm;
        end else if ((opc & `MASK_S) == `OPC_SMUL_IMM) begin
            classify = opd_pkg::op_smul_imm;
        end else if (opc == `OPC_AAM) begin
            classify = opd_pkg::op_aam;
        end else if (opc == `OPC_AAD) begin
            classify = opd_pkg::op_aad;
        end else if (opc == `OPC_CBW) begin
            classify = opd_pkg::op_cbw;
        end else if (opc == `OPC_CWD) begin
            classify = opd_pkg::op_cwd;
        end else if (r != `SH_UNDEF && (opc & `MASK_W) == `OPC_SH1) begin
            classify = opd_pkg::op_sh1;
        end else if (r != `SH_UNDEF && (opc & `MASK_W) == `OPC_SHCL) begin
            classify = opd_pkg::op_sh_cnt;
        end else if (r != `SH_UNDEF && (opc & `MASK_W) == `OPC_SHIMM) begin
            classify = opd_pkg::op_sh_imm;
        end else if ((opc & `MASK_DW) == `OPC_AND_RM) begin
            classify = opd_pkg::op_and_rm;
        end else if ((opc & `MASK_W) == `OPC_AND_ACC) begin
            classify = opd_pkg::op_and_acc;
        end else if ((opc & `MASK_W) == `OPC_GRP1) begin
            if (r == `REG_AND) classify = opd_pkg::op_and_imm;
            else if (r == `REG_OR) classify = opd_pkg::op_or_imm;
        end else if ((opc & `MASK_W) == `OPC_TEST_RM) begin
            classify = opd_pkg::op_test_rm;
        end else if ((opc & `MASK_W) == `OPC_TEST_ACC) begin
            classify = opd_pkg::op_test_acc;
        end else if ((opc & `MASK_DW) == `OPC_OR_RM) begin
            classify = opd_pkg::op_or_rm;
        end else if ((opc & `MASK_W) == `OPC_OR_ACC) begin
            classify = opd_pkg::op_or_acc;
        end
    endfunction

    // ----------------------------------------
    // Clock counts, packed as {least, most}
    // ----------------------------------------
    function automatic logic [17:0] cycles(input opd_pkg::op_class_t c, input logic m,
                                           input logic w, input logic [7:0] n);
        logic [8:0] lo;
        logic [8:0] hi;
        logic star;
        lo = 9'd0;
        hi = 9'd0;
        star = 1'b0;
        case (c)
            opd_pkg::op_smul: begin
                star = 1'b1;
                lo = w ? (m ? `SMUL_MW_LO : `SMUL_RW_LO) : `SMUL_RB_LO;
                hi = w ? (m ? `SMUL_MW_HI : `SMUL_RW_HI) : `SMUL_RB_HI;
                if (m && !w) begin
                    lo = NARROW_BUS ? `SMUL_MB_LO_N : `SMUL_MB_LO;
                    hi = `SMUL_MB_HI;
                end
            end
            opd_pkg::op_smul_imm: begin
                lo = m ? `SMULI_M_LO : `SMULI_R_LO;
                hi = m ? `SMULI_M_HI : `SMULI_R_HI;
            end
            opd_pkg::op_udiv: begin
                star = 1'b1;
                lo = m ? (w ? `UDIV_MW : `UDIV_MB) : (w ? `UDIV_RW : `UDIV_RB);
                hi = lo;
            end
            opd_pkg::op_sdiv: begin
                star = 1'b1;
                lo = m ? (w ? `SDIV_MW_LO : `SDIV_MB_LO) : (w ? `SDIV_RW_LO : `SDIV_RB_LO);
                hi = lo + `SDIV_SPAN;
            end
            opd_pkg::op_aam: begin
                lo = `AAM_CYC;
                hi = lo;
            end
            opd_pkg::op_aad: begin
                lo = `AAD_CYC;
                hi = lo;
            end
            opd_pkg::op_cbw: begin
                lo = `CBW_CYC;
                hi = lo;
            end
            opd_pkg::op_cwd: begin
                lo = `CWD_CYC;
                hi = lo;
            end
            opd_pkg::op_sh1: begin
                lo = m ? `SH1_M : `SH1_R;
                hi = lo;
            end
            opd_pkg::op_sh_cnt, opd_pkg::op_sh_imm: begin
                lo = (m ? `SHN_M : `SHN_R) + {1'b0, n};
                hi = lo;
            end
            opd_pkg::op_and_rm, opd_pkg::op_or_rm, opd_pkg::op_test_rm: begin
                star = 1'b1;
                lo = m ? `LOG_M : `LOG_R;
                hi = lo;
            end
            opd_pkg::op_and_imm, opd_pkg::op_or_imm: begin
                star = 1'b1;
                lo = m ? `LIMM_M : `LIMM_R;
                hi = lo;
            end
            opd_pkg::op_test_imm: begin
                star = 1'b1;
                lo = m ? `TIMM_M : `LIMM_R;
                hi = lo;
            end
            opd_pkg::op_and_acc, opd_pkg::op_or_acc, opd_pkg::op_test_acc: begin
                lo = w ? `ACC_W : `ACC_B;
                hi = lo;
            end
            default: begin
                lo = 9'd0;
                hi = 9'd0;
            end
        endcase
        // Narrow bus moves a word operand as two byte transfers
        if (star && NARROW_BUS && m && w) begin
            lo = lo + `NARROW_ADD;
            hi = hi + `NARROW_ADD;
        end
        cycles = {lo, hi};
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    opd_pkg::state_t state_q, state_d;
    opd_pkg::op_class_t cls_q;
    opd_pkg::shift_op_t sh_q;
    logic [7:0] opc_q, n_q;
    logic [2:0] left_q;
    logic [8:0] lo_q, hi_q, cnt_q;
    logic word_q, mem_q, ready_q, dv_q, busy_q, done_q, inv_q;

    // ----------------------------------------
    // Byte decode
    // ----------------------------------------
    // Stage-independent views so that the entry count sees the final byte
    wire logic take = in_valid && ready_q;
    wire logic [1:0] md = in_byte[7:6];
    wire logic [2:0] rg = in_byte[5:3];
    wire logic [2:0] rm = in_byte[2:0];
    wire opd_pkg::op_class_t cls0 = classify(in_byte, 3'h0);
    wire opd_pkg::op_class_t cls_m = classify(opc_q, rg);
    wire logic need_modrm = cls0 == opd_pkg::op_invalid || cls0 == opd_pkg::op_smul_imm
        || (cls0 >= opd_pkg::op_sh1 && cls0 <= opd_pkg::op_and_rm)
        || cls0 == opd_pkg::op_test_rm || cls0 == opd_pkg::op_test_imm || cls0 == opd_pkg::op_or_rm;
    wire logic grp_opc = (in_byte & `MASK_W) == `OPC_GRP1;
    wire logic bad0 = cls0 == opd_pkg::op_invalid && !grp_opc;
    wire logic acc0 = cls0 == opd_pkg::op_and_acc || cls0 == opd_pkg::op_or_acc
        || cls0 == opd_pkg::op_test_acc;
    wire logic adj0 = cls0 == opd_pkg::op_aam || cls0 == opd_pkg::op_aad;
    // Bytes after the opcode when there is no mode byte
    wire logic [2:0] tail0 = adj0 ? 3'd1 : (acc0 ? (in_byte[0] ? 3'd2 : 3'd1) : 3'd0);
    wire logic word0 = cls0 == opd_pkg::op_smul_imm || cls0 == opd_pkg::op_cwd
        || (!adj0 && cls0 != opd_pkg::op_cbw && in_byte[0]);
    wire logic [2:0] disp = (md == `MOD_D8) ? 3'd1 :
        (md == `MOD_D16 || (md == `MOD_IND && rm == `RM_DIRECT)) ? 3'd2 : 3'd0;
    // Immediate length follows the w or s bit of the opcode, except the shift count, which is always one byte
    wire logic [2:0] imm = (cls_m == opd_pkg::op_smul_imm) ? (opc_q[1] ? 3'd1 : 3'd2) :
        (cls_m == opd_pkg::op_sh_imm) ? 3'd1 :
        (cls_m == opd_pkg::op_test_imm || cls_m == opd_pkg::op_and_imm
         || cls_m == opd_pkg::op_or_imm) ? (opc_q[0] ? 3'd2 : 3'd1) : 3'd0;
    wire logic [2:0] tail_m = disp + imm;
    wire logic adj_bad = (cls_q == opd_pkg::op_aam || cls_q == opd_pkg::op_aad)
        && in_byte != `ADJ_BASE;
    wire opd_pkg::op_class_t cls_c = (state_q == opd_pkg::st_opcode) ? cls0 :
        (state_q == opd_pkg::st_modrm) ? cls_m : cls_q;
    wire logic mem_c = (state_q == opd_pkg::st_modrm) ? (md != `MOD_REG) : mem_q;
    wire logic word_c = (state_q == opd_pkg::st_opcode) ? word0 : word_q;
    wire logic [7:0] n_c = (state_q == opd_pkg::st_modrm) ? count_register_low :
        (state_q == opd_pkg::st_tail && cls_q == opd_pkg::op_sh_imm) ? in_byte : n_q;
    wire logic [17:0] cyc_c = cycles(cls_c, mem_c, word_c, n_c);
    wire logic go_bad = take && ((state_q == opd_pkg::st_opcode && bad0)
        || (state_q == opd_pkg::st_modrm && cls_m == opd_pkg::op_invalid)
        || (state_q == opd_pkg::st_tail && left_q == 3'd1 && adj_bad));
    wire logic go_exec = state_d == opd_pkg::st_exec && state_q != opd_pkg::st_exec;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // Single-byte forms run straight from the opcode byte
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            opd_pkg::st_opcode: begin
                if (take && !bad0) begin
                    state_d = need_modrm ? opd_pkg::st_modrm :
                        (tail0 != 3'd0) ? opd_pkg::st_tail : opd_pkg::st_exec;
                end
            end
            opd_pkg::st_modrm: begin
                if (take) begin
                    state_d = (cls_m == opd_pkg::op_invalid) ? opd_pkg::st_opcode :
                        (tail_m != 3'd0) ? opd_pkg::st_tail : opd_pkg::st_exec;
                end
            end
            opd_pkg::st_tail: begin
                if (take && left_q == 3'd1) begin
                    state_d = adj_bad ? opd_pkg::st_opcode : opd_pkg::st_exec;
                end
            end
            opd_pkg::st_exec: begin
                if (cnt_q == 9'd1) begin
                    state_d = opd_pkg::st_opcode;
                end
            end
        endcase
    end

    // Decode context captured byte by byte
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            opc_q <= 8'h00;
            cls_q <= opd_pkg::op_none;
            sh_q <= opd_pkg::rotate_left;
            word_q <= 1'b0;
            mem_q <= 1'b0;
            n_q <= 8'h00;
            left_q <= 3'd0;
        end else if (take) begin
            if (state_q == opd_pkg::st_opcode) begin
                opc_q <= in_byte;
                cls_q <= cls0;
                word_q <= word0;
                mem_q <= 1'b0;
                left_q <= tail0;
            end else if (state_q == opd_pkg::st_modrm) begin
                cls_q <= cls_m;
                sh_q <= opd_pkg::shift_op_t'(rg);
                mem_q <= md != `MOD_REG;
                n_q <= count_register_low;
                left_q <= tail_m;
            end else begin
                n_q <= (cls_q == opd_pkg::op_sh_imm) ? in_byte : n_q;
                left_q <= left_q - 3'd1;
            end
        end
    end

    // Run timer; busy lasts the most clocks of the range
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state_q <= opd_pkg::st_opcode;
            cnt_q <= 9'd0;
            lo_q <= 9'd0;
            hi_q <= 9'd0;
        end else begin
            state_q <= state_d;
            cnt_q <= go_exec ? cyc_c[8:0] : (cnt_q != 9'd0 ? cnt_q - 9'd1 : 9'd0);
            lo_q <= go_exec ? cyc_c[17:9] : lo_q;
            hi_q <= go_exec ? cyc_c[8:0] : hi_q;
        end
    end

    // Status flops drive every status output directly
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ready_q <= 1'b0;
            dv_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            inv_q <= 1'b0;
        end else begin
            ready_q <= state_d != opd_pkg::st_exec;
            dv_q <= go_exec;
            busy_q <= state_d == opd_pkg::st_exec;
            done_q <= state_q == opd_pkg::st_exec && cnt_q == 9'd1;
            inv_q <= go_bad;
        end
    end

    assign in_ready = ready_q;
    assign op_class = cls_q;
    assign shift_op_select_field = sh_q;
    assign op_word = word_q;
    assign op_mem = mem_q;
    assign cyc_min = lo_q;
    assign cyc_max = hi_q;
    assign decode_valid = dv_q;
    assign busy = busy_q;
    assign done = done_q;
    assign invalid = inv_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    smul_reg_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        decode_valid && op_class == opd_pkg::op_smul && !op_mem && !op_word |-> cyc_min == 9'd25 && cyc_max == 9'd28)
        else $error("signed multiply register byte range wrong");
    udiv_word_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        decode_valid && op_class == opd_pkg::op_udiv && !op_mem && op_word |-> ##38 done)
        else $error("unsigned divide word did not end at 38");
    sdiv_span_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        decode_valid && op_class == opd_pkg::op_sdiv |-> cyc_max == cyc_min + 9'd8)
        else $error("signed divide range not eight wide");
    adj_mul_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        decode_valid && op_class == opd_pkg::op_aam |-> busy ##18 busy ##1 done)
        else $error("adjust after multiply not 19 clocks");
    adj_div_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        decode_valid && op_class == opd_pkg::op_aad |-> ##15 done)
        else $error("adjust before divide not 15 clocks");
    byte_ext_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        decode_valid && op_class == opd_pkg::op_cbw |-> busy[*2] ##1 (done && !busy))
        else $error("byte extend not 2 clocks");
    word_ext_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        decode_valid && op_class == opd_pkg::op_cwd |-> !in_ready[*4] ##1 in_ready)
        else $error("word extend not 4 clocks");
    shift_undef_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        decode_valid && op_class >= opd_pkg::op_sh1 && op_class <= opd_pkg::op_sh_imm
        |-> shift_op_select_field != opd_pkg::shift_reserved)
        else $error("undefined shift field decoded");
    acc_test_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        decode_valid && op_class == opd_pkg::op_test_acc |-> cyc_max == (op_word ? 9'd4 : 9'd3))
        else $error("accumulator test count wrong");

endmodule
`default_nettype wire

// >>> design/opd_regs.svh
`ifndef OPD_REGS_SVH
`define OPD_REGS_SVH

// ----------------------------------------
// Opcode values and masks
// ----------------------------------------
`define MASK_W 8'hfe
`define MASK_DW 8'hfc
`define MASK_S 8'hfd
`define OPC_GRP3 8'hf6
`define OPC_GRP1 8'h80
`define OPC_SMUL_IMM 8'h69
`define OPC_AAM 8'hd4
`define OPC_AAD 8'hd5
`define ADJ_BASE 8'h0a
`define OPC_CBW 8'h98
`define OPC_CWD 8'h99
`define OPC_SH1 8'hd0
`define OPC_SHCL 8'hd2
`define OPC_SHIMM 8'hc0
`define OPC_AND_RM 8'h20
`define OPC_AND_ACC 8'h24
`define OPC_TEST_RM 8'h84
`define OPC_TEST_ACC 8'ha8
`define OPC_OR_RM 8'h08
`define OPC_OR_ACC 8'h0c

// ----------------------------------------
// Second-byte fields
// ----------------------------------------
`define REG_TEST 3'h0
`define REG_OR 3'h1
`define REG_AND 3'h4
`define REG_SMUL 3'h5
`define REG_UDIV 3'h6
`define REG_SDIV 3'h7
`define SH_UNDEF 3'h6
`define MOD_REG 2'h3
`define MOD_D8 2'h1
`define MOD_D16 2'h2
`define MOD_IND 2'h0
`define RM_DIRECT 3'h6

// ----------------------------------------
// Clock counts
// ----------------------------------------
`define SMUL_RB_LO 9'd25
`define SMUL_RB_HI 9'd28
`define SMUL_RW_LO 9'd34
`define SMUL_RW_HI 9'd37
`define SMUL_MB_LO 9'd31
`define SMUL_MB_LO_N 9'd32
`define SMUL_MB_HI 9'd34
`define SMUL_MW_LO 9'd40
`define SMUL_MW_HI 9'd43
`define SMULI_R_LO 9'd22
`define SMULI_R_HI 9'd25
`define SMULI_M_LO 9'd29
`define SMULI_M_HI 9'd32
`define UDIV_RB 9'd29
`define UDIV_RW 9'd38
`define UDIV_MB 9'd35
`define UDIV_MW 9'd44
`define SDIV_RB_LO 9'd44
`define SDIV_RW_LO 9'd53
`define SDIV_MB_LO 9'd50
`define SDIV_MW_LO 9'd59
`define SDIV_SPAN 9'd8
`define AAM_CYC 9'd19
`define AAD_CYC 9'd15
`define CBW_CYC 9'd2
`define CWD_CYC 9'd4
`define SH1_R 9'd2
`define SH1_M 9'd15
`define SHN_R 9'd5
`define SHN_M 9'd17
`define LOG_R 9'd3
`define LOG_M 9'd10
`define LIMM_R 9'd4
`define LIMM_M 9'd16
`define TIMM_M 9'd10
`define ACC_B 9'd3
`define ACC_W 9'd4
`define NARROW_ADD 9'd4

`endif

// >>> design/opd_pkg.sv
package opd_pkg;
    typedef enum logic [1:0] {
        st_opcode = 2'b00, st_modrm = 2'b01, st_tail = 2'b10, st_exec = 2'b11
    } state_t;
    typedef enum logic [4:0] {
        op_none = 5'b00000, op_smul = 5'b00001, op_smul_imm = 5'b00010,
        op_udiv = 5'b00011, op_sdiv = 5'b00100, op_aam = 5'b00101,
        op_aad = 5'b00110, op_cbw = 5'b00111, op_cwd = 5'b01000,
        op_sh1 = 5'b01001, op_sh_cnt = 5'b01010, op_sh_imm = 5'b01011,
        op_and_rm = 5'b01100, op_and_imm = 5'b01101, op_and_acc = 5'b01110,
        op_test_rm = 5'b01111, op_test_imm = 5'b10000, op_test_acc = 5'b10001,
        op_or_rm = 5'b10010, op_or_imm = 5'b10011, op_or_acc = 5'b10100,
        op_invalid = 5'b10101
    } op_class_t;
    typedef enum logic [2:0] {
        rotate_left = 3'b000, rotate_right = 3'b001,
        rotate_left_through_carry = 3'b010, rotate_right_through_carry = 3'b011,
        shift_left = 3'b100, logical_shift_right = 3'b101,
        shift_reserved = 3'b110, arithmetic_shift_right = 3'b111
    } shift_op_t;
endpackage

// >>> dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic in_valid = 1'b0;
    logic [7:0] in_byte = 8'h00;
    logic [7:0] count_register_low = 8'h00;
    logic in_ready, op_word, op_mem, decode_valid, busy, done, invalid;
    opd_pkg::op_class_t op_class;
    opd_pkg::shift_op_t shift_op_select_field;
    logic [8:0] cyc_min, cyc_max;
    int n_fail = 0;
    int tests_run = 0;
    logic narrow_on = 1'b0;
    logic nar_dv, nar_busy, nar_done;
    opd_pkg::op_class_t nar_class;
    logic [8:0] nar_min, nar_max;
    wire logic nar_valid = in_valid && narrow_on;
    mul_div_logic_op_decoder mul_div_logic_op_decoder_i (.sys_clk(sys_clk), .rst_b(rst_b),
        .in_valid(in_valid), .in_byte(in_byte), .count_register_low(count_register_low),
        .in_ready(in_ready), .op_class(op_class), .shift_op_select_field(shift_op_select_field),
        .op_word(op_word), .op_mem(op_mem), .cyc_min(cyc_min), .cyc_max(cyc_max),
        .decode_valid(decode_valid), .busy(busy), .done(done), .invalid(invalid));
    // Narrow-bus copy sees bytes only in its own scenario, as its longer counts would put it out of step
    mul_div_logic_op_decoder #(.NARROW_BUS(1'b1)) mul_div_logic_op_decoder_narrow_i (.sys_clk(sys_clk),
        .rst_b(rst_b), .in_valid(nar_valid), .in_byte(in_byte), .count_register_low(count_register_low),
        .in_ready(), .op_class(nar_class), .shift_op_select_field(), .op_word(), .op_mem(),
        .cyc_min(nar_min), .cyc_max(nar_max), .decode_valid(nar_dv), .busy(nar_busy), .done(nar_done),
        .invalid());
    // ----------------------------------------
    // Clock and checking helpers
    // ----------------------------------------
    // 100 MHz clock
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic chk_num(input string s, input logic [8:0] e, input logic [8:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic chk_cls(input opd_pkg::op_class_t e, input opd_pkg::op_class_t g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("Error op_class expected %h seen %h", e, g);
        end
    endtask
    // Offer one byte and hold it until the edge that takes it; a stuck ready gives up after 100 cycles
    task automatic send(input logic [7:0] v);
        int k;
        in_valid = 1'b1;
        in_byte = v;
        k = 0;
        while (in_ready !== 1'b1 && k < 100) begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        @(posedge sys_clk);
        #1;
    endtask
    // Send n bytes (first in the top byte), then judge the decode and its busy span
    task automatic ins(input logic [31:0] b, input int n, input opd_pkg::op_class_t c,
                       input logic [8:0] lo, input logic [8:0] hi, input logic [1:0] wm);
        int k;
        for (int i = 0; i < n; i++) begin
            send(b[31-8*i -: 8]);
        end
        in_valid = 1'b0;
        chk_num("decode_valid", 9'h001, {8'h00, decode_valid});
        chk_cls(c, op_class);
        chk_num("cyc_min", lo, cyc_min);
        chk_num("cyc_max", hi, cyc_max);
        chk_num("word_mem", {7'h00, wm}, {7'h00, op_word, op_mem});
        k = 0;
        while (busy === 1'b1 && k < 300) begin
            k++;
            @(posedge sys_clk);
            #1;
        end
        chk_num("busy_len", hi, 9'(k));
        chk_num("done", 9'h001, {8'h00, done});
    endtask
    // A refused byte pulses invalid in the cycle after it is taken
    task automatic bad(input logic [31:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            send(b[31-8*i -: 8]);
        end
        in_valid = 1'b0;
        chk_num("invalid", 9'h001, {8'h00, invalid});
        @(posedge sys_clk);
        #1;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_muldiv();
        ins(32'hf6e80000, 2, opd_pkg::op_smul, 9'h19, 9'h1c, 2'b00);
        ins(32'hf7e80000, 2, opd_pkg::op_smul, 9'h22, 9'h25, 2'b10);
        ins(32'hf6681100, 3, opd_pkg::op_smul, 9'h1f, 9'h22, 2'b01);
        ins(32'hf7280000, 2, opd_pkg::op_smul, 9'h28, 9'h2b, 2'b11);
        ins(32'h6bc00500, 3, opd_pkg::op_smul_imm, 9'h16, 9'h19, 2'b10);
        ins(32'h69003412, 4, opd_pkg::op_smul_imm, 9'h1d, 9'h20, 2'b11);
        ins(32'hf6f00000, 2, opd_pkg::op_udiv, 9'h1d, 9'h1d, 2'b00);
        ins(32'hf7f00000, 2, opd_pkg::op_udiv, 9'h26, 9'h26, 2'b10);
        ins(32'hf6b01122, 4, opd_pkg::op_udiv, 9'h23, 9'h23, 2'b01);
        ins(32'hf7300000, 2, opd_pkg::op_udiv, 9'h2c, 9'h2c, 2'b11);
        ins(32'hf6f80000, 2, opd_pkg::op_sdiv, 9'h2c, 9'h34, 2'b00);
        ins(32'hf7f80000, 2, opd_pkg::op_sdiv, 9'h35, 9'h3d, 2'b10);
        ins(32'hf6380000, 2, opd_pkg::op_sdiv, 9'h32, 9'h3a, 2'b01);
        ins(32'hf7380000, 2, opd_pkg::op_sdiv, 9'h3b, 9'h43, 2'b11);
        bad(32'hf6d00000, 2);
        $display("muldiv test done");
    endtask
    task automatic t_adjust();
        ins(32'hd40a0000, 2, opd_pkg::op_aam, 9'h13, 9'h13, 2'b00);
        ins(32'hd50a0000, 2, opd_pkg::op_aad, 9'h0f, 9'h0f, 2'b00);
        bad(32'hd40b0000, 2);
        ins(32'h98000000, 1, opd_pkg::op_cbw, 9'h02, 9'h02, 2'b00);
        ins(32'h99000000, 1, opd_pkg::op_cwd, 9'h04, 9'h04, 2'b10);
        bad(32'h00000000, 1);
        $display("adjust and extend test done");
    endtask
    // Every operation field on the shift-by-one form, then the counted forms
    task automatic t_shift();
        for (int f = 0; f < 8; f++) begin
            if (f == 6) begin
                bad({8'hd1, 2'h3, 3'(f), 3'h0, 16'h0000}, 2);
            end else begin
                ins({8'hd1, 2'h3, 3'(f), 3'h0, 16'h0000}, 2, opd_pkg::op_sh1, 9'h02, 9'h02, 2'b10);
                chk_num("field", 9'(f), {6'h00, shift_op_select_field});
            end
        end
        ins(32'hd0000000, 2, opd_pkg::op_sh1, 9'h0f, 9'h0f, 2'b01);
        count_register_low = 8'h05;
        ins(32'hd2200000, 2, opd_pkg::op_sh_cnt, 9'h16, 9'h16, 2'b01);
        ins(32'hc1e80300, 3, opd_pkg::op_sh_imm, 9'h08, 9'h08, 2'b10);
        ins(32'hc0e00000, 3, opd_pkg::op_sh_imm, 9'h05, 9'h05, 2'b00);
        $display("shift test done");
    endtask
    task automatic t_logic();
        ins(32'h21c00000, 2, opd_pkg::op_and_rm, 9'h03, 9'h03, 2'b10);
        ins(32'h20000000, 2, opd_pkg::op_and_rm, 9'h0a, 9'h0a, 2'b01);
        ins(32'h81e03412, 4, opd_pkg::op_and_imm, 9'h04, 9'h04, 2'b10);
        ins(32'h80200500, 3, opd_pkg::op_and_imm, 9'h10, 9'h10, 2'b01);
        ins(32'h25341200, 3, opd_pkg::op_and_acc, 9'h04, 9'h04, 2'b10);
        ins(32'h24050000, 2, opd_pkg::op_and_acc, 9'h03, 9'h03, 2'b00);
        ins(32'h85c00000, 2, opd_pkg::op_test_rm, 9'h03, 9'h03, 2'b10);
        ins(32'h84000000, 2, opd_pkg::op_test_rm, 9'h0a, 9'h0a, 2'b01);
        ins(32'hf7c03412, 4, opd_pkg::op_test_imm, 9'h04, 9'h04, 2'b10);
        ins(32'hf6000500, 3, opd_pkg::op_test_imm, 9'h0a, 9'h0a, 2'b01);
        ins(32'ha9341200, 3, opd_pkg::op_test_acc, 9'h04, 9'h04, 2'b10);
        ins(32'ha8050000, 2, opd_pkg::op_test_acc, 9'h03, 9'h03, 2'b00);
        ins(32'h09c00000, 2, opd_pkg::op_or_rm, 9'h03, 9'h03, 2'b10);
        ins(32'h81c83412, 4, opd_pkg::op_or_imm, 9'h04, 9'h04, 2'b10);
        ins(32'h0d341200, 3, opd_pkg::op_or_acc, 9'h04, 9'h04, 2'b10);
        bad(32'h81d00000, 2);
        $display("logic test done");
    endtask
    // Judge the narrow-bus copy; both copies start idle, and the narrow one is waited out
    task automatic nar(input logic [31:0] b, input int n, input opd_pkg::op_class_t c,
                       input logic [8:0] lo, input logic [8:0] hi);
        int k;
        for (int i = 0; i < n; i++) begin
            send(b[31-8*i -: 8]);
        end
        in_valid = 1'b0;
        chk_num("nar_valid", 9'h001, {8'h00, nar_dv});
        chk_cls(c, nar_class);
        chk_num("nar_min", lo, nar_min);
        chk_num("nar_max", hi, nar_max);
        k = 0;
        while (nar_busy === 1'b1 && k < 300) begin
            k++;
            @(posedge sys_clk);
            #1;
        end
        chk_num("nar_busy_len", hi, 9'(k));
        chk_num("nar_done", 9'h001, {8'h00, nar_done});
    endtask
    // Word memory forms other than shifts and immediate multiply gain four clocks; byte memory multiply gains one on its minimum, register forms keep theirs
    task automatic t_narrow();
        narrow_on = 1'b1;
        nar(32'hf7280000, 2, opd_pkg::op_smul, 9'h2c, 9'h2f);
        nar(32'hf6681100, 3, opd_pkg::op_smul, 9'h20, 9'h22);
        nar(32'hf7300000, 2, opd_pkg::op_udiv, 9'h30, 9'h30);
        nar(32'hf7380000, 2, opd_pkg::op_sdiv, 9'h3f, 9'h47);
        nar(32'h21000000, 2, opd_pkg::op_and_rm, 9'h0e, 9'h0e);
        nar(32'hf7f00000, 2, opd_pkg::op_udiv, 9'h26, 9'h26);
        narrow_on = 1'b0;
        $display("narrow bus test done");
    endtask
    // ----------------------------------------
    // Main sequence and verdict
    // ----------------------------------------
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Reset for 20 cycles, then every scenario back to back
    initial begin
        repeat (20) @(posedge sys_clk);
        #1;
        chk_num("reset_ready", 9'h000, {8'h00, in_ready});
        chk_cls(opd_pkg::op_none, op_class);
        rst_b = 1'b1;
        t_muldiv();
        t_adjust();
        t_shift();
        t_logic();
        t_narrow();
        final_report();
    end
    // Watchdog: the scenarios need a little over a thousand cycles
    initial begin
        #300000;
        n_fail++;
        final_report();
    end
endmodule
`default_nettype wire
